// ==== dv/pclp_assertions.sv ====
// Pin-level checks between the two load port ends
`timescale 1ns/10ps
module pclp_assertions #(
    parameter int POR = 20,
    parameter int STATUS_MIN = 30
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic config_request_n,
    input wire logic status_line,
    input wire logic load_complete,
    input wire logic init_done_line,
    input wire logic host_status_oe_n
);
    localparam int RELEASE_MAX = STATUS_MIN + 20;
    logic [15:0] low_cnt;
    logic [15:0] up_cnt;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // Length of the current status low stretch
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            low_cnt <= 16'h0;
        else
            low_cnt <= status_line ? 16'h0 : low_cnt + 16'h1;
    end
    // Cycles since reset release, saturating
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            up_cnt <= 16'h0;
        else if (up_cnt != 16'hffff)
            up_cnt <= up_cnt + 16'h1;
    end
    req_low_lines_a: assert property ($fell(config_request_n) |-> ##[1:60] (!status_line && !load_complete))
        else $error("status or done not pulled low after request");
    status_min_a: assert property ($rose(status_line) |-> low_cnt >= STATUS_MIN)
        else $error("status low stretch too short");
    status_release_a: assert property ($rose(config_request_n) && host_status_oe_n |-> ##[1:RELEASE_MAX] status_line)
        else $error("status not released in time");
    por_hold_a: assert property (status_line |-> up_cnt >= POR)
        else $error("status released inside power-on delay");
    done_order_a: assert property ($rose(load_complete) |-> status_line && config_request_n)
        else $error("done released outside load phase");
    done_steady_a: assert property ((load_complete && config_request_n) [*5] |=> load_complete)
        else $error("done dropped while load clock ignored");
    init_low_a: assert property ($fell(init_done_line) |-> load_complete)
        else $error("init line low before done");
    init_end_a: assert property ($fell(init_done_line) |-> ##[1:400] init_done_line)
        else $error("initialization too long");
    user_lines_a: assert property ($rose(init_done_line) |-> status_line && load_complete)
        else $error("user mode with a line low");
endmodule

// ==== dv/pclp_tb_top.sv ====
// Bench joining host and device ends under APB control
`timescale 1ns/10ps
module pclp_tb_top;
    import pclp_pkg::*;
    logic clk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr;
    logic ow = 1'h0, od = 1'h0, os = 1'h0, ou = 1'h0, oi = 1'h0, uck = 1'h0, word_valid, load_done, user_mode;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic [DATA_W-1:0] word_data;
    pclp_word_type nw = 32'h0;
    int n_fail = 0, samples_checked = 0, cyc = 0, ecnt = 0;
    pclp_if pif();
    pclp_host #(.BLIND_WAIT_CYCLES(40)) u_pclp_host (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pins(pif.host));
    pclp_device #(.POR_CYCLES(20), .STATUS_MIN_CYCLES(30), .INIT_CYCLES(20), .UCLK_PERIODS(8)) u_pclp_device (
        .clk(clk), .rstn(rstn), .pins(pif.dev), .opt_wide(ow), .opt_decompress(od), .opt_security(os),
        .opt_init_done(oi), .opt_user_clock(ou), .image_words(nw), .user_init_clock(uck),
        .word_data(word_data), .word_valid(word_valid), .load_done(load_done), .user_mode(user_mode));
    pclp_assertions u_pclp_assertions (.clk(clk), .rstn(rstn),
        .config_request_n(pif.config_request_n), .status_line(pif.status_line),
        .load_complete(pif.load_complete), .init_done_line(pif.init_done_line),
        .host_status_oe_n(pif.host_status_oe_n));
    // Clocks and load clock rise count
    initial forever #5 clk = ~clk;
    initial forever #40 uck = ~uck;
    always @(posedge pif.load_clock) ecnt++;
    // Hang limit
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_fail++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
        output logic err);
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= {24'h0, a};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // Full load of two words: m[0] wide, m[1] decompress, m[2] security
    task automatic run_cfg(input logic [2:0] m);
        logic [31:0] rd;
        logic err;
        logic [15:0] d;
        int t, e0, r;
        r = m[1] ? (m[0] ? 4 : 2) : ((m[2] & m[0]) ? 2 : 1);
        @(posedge clk);
        ow <= m[0];
        od <= m[1];
        os <= m[2];
        ou <= m[0] ^ m[2];
        oi <= m != 3'h3;
        nw <= 32'h2;
        apb(1'h1, REG_LENGTH, 32'h2, rd, err);
        apb(1'h1, REG_CTRL, {26'h0, 1'h0, m != 3'h5, m[2], m[1], m[0], 1'h1}, rd, err);
        for (int i = 0; i < 2; i++)
        begin
            d = i ? 16'hc3a5 : 16'h5a3c;
            e0 = ecnt;
            apb(1'h1, REG_DATA, {16'h0, d}, rd, err);
            while (word_valid !== 1'h1) @(posedge clk);
            chk("word", m[0] ? d : {8'h0, d[7:0]}, word_data);
            chk("ratio", r, ecnt - e0);
            if (i == 0)
                chk("early_done", 1'h0, load_done);
        end
        repeat (2) @(posedge clk);
        chk("init_low", m == 3'h3, pif.init_done_line);
        t = 0;
        while (user_mode !== 1'h1) @(posedge clk) t++;
        chk("done", 1'h1, load_done);
        chk("init_time", 1'h1, t >= (ou ? 56 : 20));
        chk("lines", 3'h7, {pif.status_line, pif.load_complete, pif.init_done_line});
    endtask
    // Main sequence
    initial
    begin
        logic [31:0] rd;
        logic err;
        repeat (8) @(posedge clk);
        rstn <= 1'h1;
        repeat (2) @(posedge clk);
        chk("por_status", 1'h0, pif.status_line);
        chk("por_done", 1'h0, pif.load_complete);
        apb(1'h0, REG_CTRL, 32'h0, rd, err);
        chk("ctrl_reset", CTRL_RESET, rd);
        for (int m = 0; m < 8; m++)
            run_cfg(m[2:0]);
        apb(1'h0, 8'h10, 32'h0, rd, err);
        chk("unmapped_err", 1'h1, err);
        chk("unmapped_data", 32'h0, rd);
        apb(1'h0, REG_STATUS, 32'h0, rd, err);
        chk("status_reg", 32'he, rd);
        end_sim();
    end
endmodule

// ==== hw/pclp_device.sv ====
// Device end of the parallel configuration load port
`timescale 1ns/10ps
module pclp_device
    import pclp_pkg::*;
#(
    parameter int POR_CYCLES = pclp_pkg::POR_CYC,
    parameter int STATUS_MIN_CYCLES = pclp_pkg::STATUS_LOW_MIN_CYC,
    parameter int INIT_CYCLES = pclp_pkg::INIT_MIN_CYC,
    parameter int UCLK_PERIODS = pclp_pkg::UCLK_INIT_PERIODS
) (
    input wire logic clk,
    input wire logic rstn,
    pclp_if.dev pins,
    input wire logic opt_wide,
    input wire logic opt_decompress,
    input wire logic opt_security,
    input wire logic opt_init_done,
    input wire logic opt_user_clock,
    input wire pclp_pkg::pclp_word_type image_words,
    input wire logic user_init_clock,
    output logic [pclp_pkg::DATA_W-1:0] word_data,
    output logic word_valid,
    output logic load_done,
    output logic user_mode
);
    import pclp_pkg::*;

    typedef enum logic [2:0] {
        ST_POR,
        ST_RESET,
        ST_LOAD,
        ST_DONE_WAIT,
        ST_INIT_OSC,
        ST_UCLK_WAIT,
        ST_INIT_UCLK,
        ST_USER
    } pclp_dev_state_type;

    localparam int SYNC_W = DATA_W + 4;
    localparam int SYNC_LAG = 2; // Falls seen this soon after done left the pin before done rose

    pclp_dev_state_type state;
    pclp_dev_state_type next_state;
    pclp_cnt_type cnt;
    pclp_ratio_type clk_in_word;
    pclp_ratio_type ratio;
    pclp_word_type word_cnt;
    pclp_word_type words_needed;
    logic [1:0] fall_cnt;
    logic [SYNC_W-1:0] sync_q;
    logic req_n_s;
    logic lclk_s;
    logic status_s;
    logic uclk_s;
    logic [DATA_W-1:0] data_s;
    logic lclk_prev;
    logic uclk_prev;
    logic lclk_rise;
    logic lclk_fall;
    logic uclk_rise;
    logic wide;
    logic init_en;
    logic use_uclk;
    logic all_words;

    // Bring pins and the user clock into the clk domain
    pclp_sync #(.W(SYNC_W)) u_sync (
        .clk(clk),
        .rstn(rstn),
        .d({pins.config_request_n, pins.load_clock, pins.status_line, user_init_clock, pins.load_data}),
        .q(sync_q)
    );

    assign req_n_s = sync_q[DATA_W+3];
    assign lclk_s = sync_q[DATA_W+2];
    assign status_s = sync_q[DATA_W+1];
    assign uclk_s = sync_q[DATA_W];
    assign data_s = sync_q[DATA_W-1:0];

    // Edge detection on synchronised clocks
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            lclk_prev <= 1'b0;
            uclk_prev <= 1'b0;
        end
        else
        begin
            lclk_prev <= lclk_s;
            uclk_prev <= uclk_s;
        end
    end

    assign lclk_rise = lclk_s & ~lclk_prev;
    assign lclk_fall = ~lclk_s & lclk_prev;
    assign uclk_rise = uclk_s & ~uclk_prev;
    assign all_words = (word_cnt == words_needed) && (words_needed != '0);

    // Next state of the configuration sequence
    always_comb
    begin
        next_state = state;
        case (state)
            ST_POR:
                if (cnt >= pclp_cnt_type'(POR_CYCLES - 1))
                    next_state = ST_RESET;
            ST_RESET:
                if (req_n_s && cnt >= pclp_cnt_type'(STATUS_MIN_CYCLES - 1))
                    next_state = ST_LOAD;
            ST_LOAD:
                if (all_words)
                    next_state = ST_DONE_WAIT;
            ST_DONE_WAIT:
                if (lclk_fall && cnt >= pclp_cnt_type'(SYNC_LAG) && fall_cnt == 2'(FALLS_AFTER_DONE - 1))
                    next_state = use_uclk ? ST_UCLK_WAIT : ST_INIT_OSC;
            ST_INIT_OSC:
                if (cnt >= pclp_cnt_type'(INIT_CYCLES - 1))
                    next_state = ST_USER;
            ST_UCLK_WAIT:
                if (cnt >= pclp_cnt_type'(UCLK_ENABLE_CYC - 1))
                    next_state = ST_INIT_UCLK;
            ST_INIT_UCLK:
                if (uclk_rise && cnt >= pclp_cnt_type'(UCLK_PERIODS - 1))
                    next_state = ST_USER;
            ST_USER:
                next_state = ST_USER;
            default:
                next_state = ST_POR;
        endcase
        if (!req_n_s && state != ST_POR)
            next_state = ST_RESET;
    end

    // State register and phase timer
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= ST_POR;
            cnt <= '0;
        end
        else
        begin
            state <= next_state;
            if (next_state != state || (state == ST_RESET && !req_n_s))
                cnt <= '0;
            else if (state == ST_INIT_UCLK)
                cnt <= cnt + pclp_cnt_type'(uclk_rise);
            else if (cnt != '1)
                cnt <= cnt + 1'b1;
        end
    end

    // Options taken when the load phase opens
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wide <= 1'b0;
            ratio <= RATIO_ONE;
            init_en <= 1'b0;
            use_uclk <= 1'b0;
            words_needed <= '0;
        end
        else if (state == ST_RESET && next_state == ST_LOAD)
        begin
            wide <= opt_wide;
            ratio <= pclp_ratio(opt_wide, opt_decompress, opt_security);
            init_en <= opt_init_done;
            use_uclk <= opt_user_clock;
            words_needed <= image_words;
        end
    end

    // Word capture on rising load clock edges while loading
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            clk_in_word <= '0;
            word_cnt <= '0;
            word_data <= '0;
            word_valid <= 1'b0;
        end
        else
        begin
            word_valid <= 1'b0;
            if (state != ST_LOAD)
            begin
                clk_in_word <= '0;
                if (next_state == ST_RESET)
                    word_cnt <= '0;
            end
            else if (lclk_rise && status_s && !all_words)
            begin
                if (clk_in_word == ratio - 1'b1)
                begin
                    clk_in_word <= '0;
                    word_cnt <= word_cnt + 1'b1;
                    word_valid <= 1'b1;
                    word_data <= wide ? data_s : {{(DATA_W-NARROW_W){1'b0}}, data_s[NARROW_W-1:0]};
                end
                else
                    clk_in_word <= clk_in_word + 1'b1;
            end
        end
    end

    // Falling edges counted after done is released
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            fall_cnt <= '0;
        else if (state != ST_DONE_WAIT)
            fall_cnt <= '0;
        else if (lclk_fall && cnt >= pclp_cnt_type'(SYNC_LAG))
            fall_cnt <= fall_cnt + 1'b1;
    end

    // Open-drain pin drive and user status
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pins.dev_status_o <= 1'b0;
            pins.dev_status_oe_n <= 1'b0;
            pins.dev_done_o <= 1'b0;
            pins.dev_done_oe_n <= 1'b0;
            pins.dev_init_o <= 1'b0;
            pins.dev_init_oe_n <= 1'b1;
            load_done <= 1'b0;
            user_mode <= 1'b0;
        end
        else
        begin
            pins.dev_status_o <= 1'b0;
            pins.dev_done_o <= 1'b0;
            pins.dev_init_o <= 1'b0;
            pins.dev_status_oe_n <= !(next_state == ST_POR || next_state == ST_RESET);
            pins.dev_done_oe_n <= !(next_state == ST_POR || next_state == ST_RESET
                                    || next_state == ST_LOAD);
            pins.dev_init_oe_n <= !(init_en && (next_state == ST_DONE_WAIT || next_state == ST_INIT_OSC
                                    || next_state == ST_UCLK_WAIT || next_state == ST_INIT_UCLK));
            load_done <= (next_state != ST_POR && next_state != ST_RESET && next_state != ST_LOAD);
            user_mode <= (next_state == ST_USER);
        end
    end
endmodule

// ==== hw/pclp_host.sv ====
// Host end: APB-controlled driver of the parallel configuration load port
`timescale 1ns/10ps
module pclp_host
    import pclp_pkg::*;
#(
    parameter int BLIND_WAIT_CYCLES = pclp_pkg::STATUS_LOW_MAX_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    pclp_if.host pins
);
    import pclp_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE,
        H_REQ,
        H_WAIT,
        H_GAP,
        H_SEND,
        H_FINISH
    } pclp_host_state_type;

    pclp_host_state_type state;
    pclp_cnt_type cnt;
    logic [CTRL_W-1:0] ctrl;
    pclp_word_type length;
    pclp_word_type sent;
    logic [DATA_W-1:0] word;
    logic word_full;
    logic [1:0] half_cnt;
    logic tick;
    pclp_ratio_type pulses;
    logic [1:0] falls;
    logic [2:0] sync_q;
    logic status_s;
    logic done_s;
    logic init_s;
    logic access;
    logic commit;
    logic mapped;
    logic start;
    logic word_taken;

    pclp_sync #(.W(3)) u_sync (
        .clk(clk),
        .rstn(rstn),
        .d({pins.status_line, pins.load_complete, pins.init_done_line}),
        .q(sync_q)
    );

    assign status_s = sync_q[2];
    assign done_s = sync_q[1];
    assign init_s = sync_q[0];
    assign access = psel & penable & ~pready;
    assign commit = psel & penable & pready & pwrite;
    assign mapped = paddr[7:0] == REG_CTRL || paddr[7:0] == REG_LENGTH
                    || paddr[7:0] == REG_DATA || paddr[7:0] == REG_STATUS;
    assign start = commit && paddr[7:0] == REG_CTRL && pwdata[CTRL_START] && state == H_IDLE;
    assign tick = half_cnt == 2'(LCLK_HALF_CYC - 1);
    assign word_taken = state == H_SEND && tick && pins.load_clock && pulses == RATIO_ONE;

    // APB answer; a data write waits while the word slot is full
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
        else if (access && !(pwrite && paddr[7:0] == REG_DATA && word_full))
        begin
            pready <= 1'b1;
            pslverr <= !mapped;
            case (paddr[7:0])
                REG_CTRL: prdata <= {26'h0, ctrl};
                REG_LENGTH: prdata <= length;
                REG_STATUS: prdata <= {27'h0, word_full, init_s, done_s, status_s, state != H_IDLE};
                default: prdata <= '0;
            endcase
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Control, length and word slot
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl <= CTRL_RESET;
            length <= '0;
            word <= '0;
            word_full <= 1'b0;
        end
        else
        begin
            if (commit && paddr[7:0] == REG_CTRL)
                ctrl <= {pwdata[CTRL_W-1:1], 1'b0};
            if (commit && paddr[7:0] == REG_LENGTH)
                length <= pwdata;
            if (commit && paddr[7:0] == REG_DATA)
            begin
                word <= pwdata[DATA_W-1:0];
                word_full <= 1'b1;
            end
            else if (word_taken || state == H_IDLE)
                word_full <= 1'b0;
        end
    end

    // Load clock half-period divider
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            half_cnt <= '0;
        else
            half_cnt <= tick ? 2'h0 : half_cnt + 1'b1;
    end

    // Host sequence and load clock drive
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= H_IDLE;
            cnt <= '0;
            sent <= '0;
            pulses <= '0;
            falls <= '0;
            pins.config_request_n <= 1'b1;
            pins.load_clock <= 1'b0;
            pins.load_data <= '0;
            pins.host_status_o <= 1'b0;
            pins.host_status_oe_n <= 1'b1;
        end
        else
        begin
            pins.host_status_o <= 1'b0;
            pins.host_status_oe_n <= !ctrl[CTRL_HOLD_STATUS];
            cnt <= (cnt != '1) ? cnt + 1'b1 : cnt;
            case (state)
                H_IDLE:
                    if (start)
                    begin
                        state <= H_REQ;
                        cnt <= '0;
                        sent <= '0;
                        pins.config_request_n <= 1'b0;
                    end
                H_REQ:
                    if (cnt >= pclp_cnt_type'(REQ_LOW_MIN_CYC - 1))
                    begin
                        state <= H_WAIT;
                        cnt <= '0;
                        pins.config_request_n <= 1'b1;
                    end
                H_WAIT:
                    if (ctrl[CTRL_MONITOR] ? status_s : cnt >= pclp_cnt_type'(BLIND_WAIT_CYCLES - 1))
                    begin
                        state <= H_GAP;
                        cnt <= '0;
                    end
                H_GAP:
                    if (!ctrl[CTRL_MONITOR] || cnt >= pclp_cnt_type'(STATUS_TO_CLK_CYC - 1))
                    begin
                        state <= H_SEND;
                        pulses <= '0;
                    end
                H_SEND:
                    if (tick)
                    begin
                        if (pins.load_clock)
                        begin
                            pins.load_clock <= 1'b0;
                            pulses <= pulses - 1'b1;
                            sent <= sent + pclp_word_type'(pulses == RATIO_ONE);
                        end
                        else if (pulses != '0)
                            pins.load_clock <= 1'b1;
                        else if (sent == length && done_s)
                        begin
                            state <= H_FINISH;
                            falls <= '0;
                        end
                        else if (word_full && sent != length)
                        begin
                            pins.load_data <= ctrl[CTRL_WIDE] ? word
                                              : {{(DATA_W-NARROW_W){1'b0}}, word[NARROW_W-1:0]};
                            pulses <= pclp_ratio(ctrl[CTRL_WIDE], ctrl[CTRL_DECOMP], ctrl[CTRL_SECURE]);
                        end
                    end
                H_FINISH:
                    if (tick)
                    begin
                        pins.load_clock <= !pins.load_clock;
                        if (pins.load_clock)
                        begin
                            falls <= falls + 1'b1;
                            if (falls == 2'(FALLS_AFTER_DONE - 1))
                                state <= H_IDLE;
                        end
                    end
                default:
                    state <= H_IDLE;
            endcase
        end
    end
endmodule

// ==== hw/pclp_sync.sv ====
// Two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/10ps
module pclp_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// ==== inc/pclp_if.sv ====
// Pins between the configuration host and the loading device
`timescale 1ns/10ps
interface pclp_if;
    import pclp_pkg::*;
    logic config_request_n;
    logic load_clock;
    logic [DATA_W-1:0] load_data;
    logic status_line;
    logic load_complete;
    logic init_done_line;
    logic dev_status_o;
    logic dev_status_oe_n;
    logic host_status_o;
    logic host_status_oe_n;
    logic dev_done_o;
    logic dev_done_oe_n;
    logic dev_init_o;
    logic dev_init_oe_n;

    // Open-drain lines with pull-ups
    assign status_line = ~((~dev_status_oe_n & ~dev_status_o) | (~host_status_oe_n & ~host_status_o));
    assign load_complete = ~(~dev_done_oe_n & ~dev_done_o);
    assign init_done_line = ~(~dev_init_oe_n & ~dev_init_o);

    modport dev (input config_request_n, input load_clock, input load_data, input status_line,
                 output dev_status_o, output dev_status_oe_n, output dev_done_o, output dev_done_oe_n,
                 output dev_init_o, output dev_init_oe_n);
    modport host (output config_request_n, output load_clock, output load_data,
                  output host_status_o, output host_status_oe_n,
                  input status_line, input load_complete, input init_done_line);
endinterface

// ==== inc/pclp_pkg.sv ====
// Constants, types and helpers shared by both ends of the parallel load port
package pclp_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int DATA_W = 16;
    localparam int NARROW_W = 8;
    localparam int CNT_W = 18;
    localparam int WORD_CNT_W = 32;
    typedef logic [CNT_W-1:0] pclp_cnt_type;
    typedef logic [2:0] pclp_ratio_type;
    typedef logic [WORD_CNT_W-1:0] pclp_word_type;

    // Times in their own units
    localparam int REQ_TO_LOW_NS = 600;
    localparam int REQ_LOW_MIN_US = 2;
    localparam int STATUS_LOW_MIN_US = 268;
    localparam int STATUS_LOW_MAX_US = 1506;
    localparam int STATUS_TO_CLK_US = 2;
    localparam int INIT_MIN_US = 175;
    localparam int INIT_MAX_US = 437;
    localparam int POR_DELAY_US = 100;
    localparam int LOAD_CLK_MIN_PERIOD_NS = 8;
    localparam int UCLK_ENABLE_PERIODS = 4;
    localparam int UCLK_INIT_PERIODS = 8576;
    localparam int FALLS_AFTER_DONE = 2;
    localparam int NS_PER_US = 1000;

    // Cycle counts: least times round up, longest round down
    localparam int REQ_TO_LOW_CYC = REQ_TO_LOW_NS / CLK_PERIOD_NS;
    localparam int REQ_LOW_MIN_CYC = (REQ_LOW_MIN_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STATUS_LOW_MIN_CYC = (STATUS_LOW_MIN_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STATUS_LOW_MAX_CYC = (STATUS_LOW_MAX_US * NS_PER_US) / CLK_PERIOD_NS;
    localparam int STATUS_TO_CLK_CYC = (STATUS_TO_CLK_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_MIN_CYC = (INIT_MIN_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POR_CYC = (POR_DELAY_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int UCLK_ENABLE_CYC =
        (UCLK_ENABLE_PERIODS * LOAD_CLK_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LCLK_HALF_CYC = 2;

    // Load clocks per word
    localparam pclp_ratio_type RATIO_ONE = 3'h1;
    localparam pclp_ratio_type RATIO_TWO = 3'h2;
    localparam pclp_ratio_type RATIO_FOUR = 3'h4;

    // Host register map on APB
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LENGTH = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam int CTRL_START = 0;
    localparam int CTRL_WIDE = 1;
    localparam int CTRL_DECOMP = 2;
    localparam int CTRL_SECURE = 3;
    localparam int CTRL_MONITOR = 4;
    localparam int CTRL_HOLD_STATUS = 5;
    localparam int CTRL_W = 6;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h10;

    // Clocks per word for a width and feature set
    function automatic pclp_ratio_type pclp_ratio(input logic wide, input logic decomp, input logic secure);
        pclp_ratio_type r;
        r = RATIO_ONE;
        if (decomp)
            r = wide ? RATIO_FOUR : RATIO_TWO;
        else if (secure && wide)
            r = RATIO_TWO;
        return r;
    endfunction
endpackage
